//--- hw/fam_framer.sv
// Flow-established notice builder and flow-change request receiver
//
// Summary of operation
// R1 - Node sends notice once setup completes, forward and reverse flow reported
// R2 - Octet 0 originator identifier, octet 1 flow identifier
// R3 - Octet 2 result code 0x00..0x02; reserved codes never sent
// R4 - Octets 3-4 rejected attributes, meaningful only for code 0x02
// R5 - Octet 5 is 0x01 for bidirectional, else zero
// R6 - Octet 6 reverse flow identifier only when bidirectional
// R7 - Tunnel octet 0x00 direct, 0x01 tunnel
// R8 - Endpoint node identifier octet follows the tunnel octet
// R9 - Relay path list appended only when tunnel is one
// R10 - Direction flag picks unidirectional or bidirectional list layout
// R11 - Unidirectional list: count n then n hop identifiers
// R12 - Bidirectional list: count then forward/reverse pairs to octet 2n
// R13 - Tunnel notice lists every hop, plus reverse hops if bidirectional
// R14 - Master sends change request to originator, both ends if bidirectional
// R15 - Request: originator, flow, then N-byte proposed specification
// R16 - Request octet N+3 direction, one bidirectional
// R17 - Reverse identifier and reverse specification only when direction is one
// R18 - Bidirectional change may cover one or both directions; accept either
// R19 - Request octet N+2 undefined; skipped unchecked
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fam_defines.svh"
module fam_framer (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [7:0] tx_data,
	output logic tx_valid,
	output logic tx_last,
	input wire logic tx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_last,
	output logic rx_ready,
	output logic irq
);
	import fam_pkg::*;

	fam_top_st_t r, n;
	fam_rq_if rq ();
	logic [7:0] path_mem [`FAM_PATH_DEPTH];
	logic [`FAM_NEV-1:0] ev;
	logic [`FAM_NEV-1:0] clr;
	logic [`FAM_NEV-1:0] status;
	logic path_we;
	logic wr_acc;

	fam_rq_parser u_parser (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.rx_data(rx_data),
		.rx_valid(rx_valid && r.rx_rdy),
		.rx_last(rx_last),
		.rq(rq.prs)
	);

	fam_irq u_irq (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ev(ev),
		.clr(clr),
		.mask(r.mask),
		.status(status),
		.irq(irq)
	);

	// Writes land on the edge where waitrequest is seen low
	assign wr_acc = avs_write && !r.waitreq;
	assign path_we = wr_acc && (avs_address == `FAM_REG_PATH);

	always_comb begin
		logic [4:0] entries;
		logic load;
		logic [7:0] code;
		logic bidir;
		logic tunnel;
		entries = '0;
		load = 1'b0;
		code = r.hdr[`FAM_HDR_CODE];
		bidir = r.opt[`FAM_OPT_DIR];
		tunnel = r.opt[`FAM_OPT_TUN];
		n = r;
		ev = '0;
		clr = '0;
		n.rx_rdy = 1'b1;

		// One wait cycle, then a one-cycle answer
		n.waitreq = !((avs_read || avs_write) && r.waitreq);
		if ((avs_read || avs_write) && r.waitreq) begin
			unique case (avs_address)
				`FAM_REG_CTRL: n.rdata = {30'h0,
					(r.st != ST_IDLE) || r.tx_valid, 1'b0};
				`FAM_REG_HDR: n.rdata = r.hdr;
				`FAM_REG_OPT: n.rdata = r.opt;
				`FAM_REG_STAT: n.rdata = {{(32-`FAM_NEV){1'b0}}, status};
				`FAM_REG_MASK: n.rdata = {{(32-`FAM_NEV){1'b0}}, r.mask};
				`FAM_REG_RQID: n.rdata = {rq.rev, 7'h00, rq.dir[0], rq.flow,
					rq.orig};
				`FAM_REG_RQSPEC: n.rdata = rq.spec;
				`FAM_REG_RQRSPEC: n.rdata = rq.rspec;
				`FAM_REG_RQFLAG: n.rdata = {31'h0, rq.rspec_ok};
				default: n.rdata = '0;
			endcase
		end

		if (wr_acc) begin
			unique case (avs_address)
				`FAM_REG_HDR: n.hdr = avs_writedata;
				`FAM_REG_OPT: n.opt = avs_writedata;
				`FAM_REG_MASK: n.mask = avs_writedata[`FAM_NEV-1:0];
				`FAM_REG_STAT: clr = avs_writedata[`FAM_NEV-1:0];
				default: ;
			endcase
		end

		// Start is ignored until the last octet of a notice is loaded, even while that octet is still waiting to leave
		if (wr_acc && (avs_address == `FAM_REG_CTRL) &&
			avs_writedata[`FAM_CTRL_START] && (r.st == ST_IDLE)) begin
			if (code > `FAM_RC_NOCAP) begin
				ev[`FAM_EV_REFUSE] = 1'b1; // R3
			end else begin
				n.st = ST_HDR; // R1
				n.idx = '0;
			end
		end

		entries = bidir ? {r.opt[`FAM_OPT_CNT], 1'b0} :
			{1'b0, r.opt[`FAM_OPT_CNT]}; // R10

		if (r.tx_valid && tx_ready) begin
			n.tx_valid = 1'b0;
			if (r.tx_last) ev[`FAM_EV_SENT] = 1'b1;
		end

		load = (r.st != ST_IDLE) && (!r.tx_valid || tx_ready);
		if (load) begin
			n.tx_valid = 1'b1;
			n.tx_last = 1'b0;
			unique case (r.st)
				ST_IDLE: ;
				ST_HDR: begin
					n.idx = r.idx + 5'd1;
					case (r.idx)
						`FAM_NO_ORIG: n.tx_data = r.hdr[`FAM_HDR_ORIG]; // R2
						`FAM_NO_FLOW: n.tx_data = r.hdr[`FAM_HDR_FLOW]; // R2
						`FAM_NO_CODE: n.tx_data = code; // R3
						// Attributes zeroed unless capacity was short
						`FAM_NO_ATTR_LO: n.tx_data = (code == `FAM_RC_NOCAP) ?
							r.opt[`FAM_OPT_ATTR_LO] : 8'h00; // R4
						`FAM_NO_ATTR_HI: n.tx_data = (code == `FAM_RC_NOCAP) ?
							r.opt[`FAM_OPT_ATTR_HI] : 8'h00; // R4
						`FAM_NO_DIR: begin
							n.tx_data = bidir ? `FAM_DIR_BIDIR : `FAM_DIR_UNI; // R5
							n.st = bidir ? ST_REV : ST_TUN; // R6
						end
						default: n.tx_data = 8'h00;
					endcase
				end
				ST_REV: begin
					n.tx_data = r.opt[`FAM_OPT_REV]; // R6
					n.st = ST_TUN;
				end
				ST_TUN: begin
					n.tx_data = tunnel ? `FAM_TUN_RELAY : `FAM_TUN_DIRECT; // R7
					n.st = ST_END;
				end
				ST_END: begin
					n.tx_data = r.hdr[`FAM_HDR_ENDP]; // R8
					n.tx_last = !tunnel; // R9
					n.st = tunnel ? ST_CNT : ST_IDLE; // R9
				end
				ST_CNT: begin
					n.tx_data = {4'h0, r.opt[`FAM_OPT_CNT]}; // R11
					n.tx_last = (entries == 5'd0);
					n.st = (entries == 5'd0) ? ST_IDLE : ST_LIST;
					n.idx = '0;
				end
				ST_LIST: begin
					// Bidirectional pairs sit forward then reverse
					n.tx_data = path_mem[r.idx]; // R12
					n.idx = r.idx + 5'd1;
					n.tx_last = (r.idx == entries - 5'd1); // R13
					if (r.idx == entries - 5'd1) n.st = ST_IDLE; // R11
				end
			endcase
		end

		ev[`FAM_EV_RQ_OK] = rq.done;
		ev[`FAM_EV_RQ_BAD] = rq.bad;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
			r.waitreq <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Hop list storage; rewriting it mid-notice alters the bytes still to go
	always_ff @(posedge ref_clk) begin
		if (path_we) path_mem[avs_writedata[`FAM_PATH_IDX]] <=
			avs_writedata[`FAM_PATH_DATA];
	end

	assign avs_readdata = r.rdata;
	assign avs_waitrequest = r.waitreq;
	assign tx_data = r.tx_data;
	assign tx_valid = r.tx_valid;
	assign tx_last = r.tx_last;
	assign rx_ready = r.rx_rdy;
endmodule : fam_framer
`default_nettype wire

//--- hw/fam_irq.sv
// Sticky event status with mask and level interrupt
`timescale 1ns/100ps
`default_nettype none
`include "fam_defines.svh"
module fam_irq (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [`FAM_NEV-1:0] ev,
	input wire logic [`FAM_NEV-1:0] clr,
	input wire logic [`FAM_NEV-1:0] mask,
	output logic [`FAM_NEV-1:0] status,
	output logic irq
);
	import fam_pkg::*;
	fam_irq_st_t r, n;
	always_comb begin
		n = r;
		// Set wins over a clear in the same cycle
		n.status = (r.status & ~clr) | ev;
		n.irq = |(n.status & mask);
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
	assign status = r.status;
	assign irq = r.irq;
endmodule : fam_irq
`default_nettype wire

//--- hw/fam_rq_parser.sv
// Parser for the flow-change request payload
`timescale 1ns/100ps
`default_nettype none
`include "fam_defines.svh"
module fam_rq_parser (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_last,
	fam_rq_if.prs rq
);
	import fam_pkg::*;
	fam_prs_st_t r, n;
	always_comb begin
		logic [5:0] len;
		logic good;
		len = '0;
		good = 1'b0;
		n = r;
		n.done = 1'b0;
		n.bad = 1'b0;
		if (rx_valid) begin
			if (r.cnt == `FAM_RQ_ORIG) n.orig = rx_data; // R15
			if (r.cnt == `FAM_RQ_FLOW) n.flow = rx_data; // R15
			for (int k = 0; k < `FAM_SPEC_LEN; k++) begin
				if (r.cnt == 6'(`FAM_RQ_SPEC + k)) n.spec[k*8 +: 8] = rx_data; // R15
			end
			// Spare octet before the direction field is never examined
			// R19
			if (r.cnt == `FAM_RQ_DIR) n.dir = rx_data; // R16
			if (r.cnt == `FAM_RQ_REV) n.rev = rx_data; // R17
			for (int k = 0; k < `FAM_RSPEC_LEN; k++) begin
				if (r.cnt == 6'(`FAM_RQ_RSPEC + k)) n.rspec[k*8 +: 8] = rx_data; // R17
			end
			if (!(&r.cnt)) n.cnt = r.cnt + 6'h01;
			if (rx_last) begin
				n.cnt = '0;
				len = r.cnt + 6'h01;
				if (n.dir == `FAM_DIR_UNI) begin
					good = (len == `FAM_RQ_LEN_UNI); // R17
					n.rspec_ok = 1'b0;
				end else if (n.dir == `FAM_DIR_BIDIR) begin
					// Either one direction or both may be revised
					good = (len == `FAM_RQ_LEN_BMIN) || (len == `FAM_RQ_LEN_BFULL); // R18
					n.rspec_ok = (len == `FAM_RQ_LEN_BFULL); // R18
				end
				n.done = good;
				n.bad = !good;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
	assign rq.orig = r.orig;
	assign rq.flow = r.flow;
	assign rq.spec = r.spec;
	assign rq.dir = r.dir;
	assign rq.rev = r.rev;
	assign rq.rspec = r.rspec;
	assign rq.rspec_ok = r.rspec_ok;
	assign rq.done = r.done;
	assign rq.bad = r.bad;
endmodule : fam_rq_parser
`default_nettype wire

//--- inc/fam_defines.svh
// Register offsets, field positions, codes and octet positions of the framer
`ifndef FAM_DEFINES_SVH
`define FAM_DEFINES_SVH
`define FAM_REG_CTRL 6'h00
`define FAM_REG_HDR 6'h04
`define FAM_REG_OPT 6'h08
`define FAM_REG_PATH 6'h0c
`define FAM_REG_STAT 6'h10
`define FAM_REG_MASK 6'h14
`define FAM_REG_RQID 6'h18
`define FAM_REG_RQSPEC 6'h1c
`define FAM_REG_RQRSPEC 6'h20
`define FAM_REG_RQFLAG 6'h24
`define FAM_CTRL_START 0
`define FAM_CTRL_BUSY 1
`define FAM_HDR_ORIG 7:0
`define FAM_HDR_FLOW 15:8
`define FAM_HDR_CODE 23:16
`define FAM_HDR_ENDP 31:24
`define FAM_OPT_ATTR_LO 7:0
`define FAM_OPT_ATTR_HI 15:8
`define FAM_OPT_DIR 16
`define FAM_OPT_TUN 17
`define FAM_OPT_CNT 23:20
`define FAM_OPT_REV 31:24
`define FAM_PATH_DATA 7:0
`define FAM_PATH_IDX 12:8
`define FAM_RC_SUCCESS 8'h00
`define FAM_RC_MAXFLOWS 8'h01
`define FAM_RC_NOCAP 8'h02
`define FAM_DIR_UNI 8'h00
`define FAM_DIR_BIDIR 8'h01
`define FAM_TUN_DIRECT 8'h00
`define FAM_TUN_RELAY 8'h01
`define FAM_NO_ORIG 5'd0
`define FAM_NO_FLOW 5'd1
`define FAM_NO_CODE 5'd2
`define FAM_NO_ATTR_LO 5'd3
`define FAM_NO_ATTR_HI 5'd4
`define FAM_NO_DIR 5'd5
`define FAM_SPEC_LEN 4
`define FAM_RSPEC_LEN 4
`define FAM_PATH_DEPTH 32
`define FAM_NEV 4
`define FAM_EV_SENT 0
`define FAM_EV_RQ_OK 1
`define FAM_EV_RQ_BAD 2
`define FAM_EV_REFUSE 3
`define FAM_RQ_ORIG 6'd0
`define FAM_RQ_FLOW 6'd1
`define FAM_RQ_SPEC 2
`define FAM_RQ_DIR (6'd`FAM_SPEC_LEN + 6'd3)
`define FAM_RQ_REV (6'd`FAM_SPEC_LEN + 6'd4)
`define FAM_RQ_RSPEC (`FAM_SPEC_LEN + 5)
`define FAM_RQ_LEN_UNI (6'd`FAM_SPEC_LEN + 6'd4)
`define FAM_RQ_LEN_BMIN (6'd`FAM_SPEC_LEN + 6'd5)
`define FAM_RQ_LEN_BFULL (6'd`FAM_SPEC_LEN + 6'd5 + 6'd`FAM_RSPEC_LEN)
`endif

//--- inc/fam_pkg.sv
// Types shared by the framer modules
`include "fam_defines.svh"
package fam_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_REV, ST_TUN, ST_END, ST_CNT,
		ST_LIST} fam_tx_st_t;
	typedef struct packed {
		logic waitreq;
		logic [31:0] rdata;
		logic [31:0] hdr;
		logic [31:0] opt;
		logic [`FAM_NEV-1:0] mask;
		fam_tx_st_t st;
		logic [4:0] idx;
		logic [7:0] tx_data;
		logic tx_valid;
		logic tx_last;
		logic rx_rdy;
	} fam_top_st_t;
	typedef struct packed {
		logic [5:0] cnt;
		logic [7:0] orig;
		logic [7:0] flow;
		logic [`FAM_SPEC_LEN*8-1:0] spec;
		logic [7:0] dir;
		logic [7:0] rev;
		logic [`FAM_RSPEC_LEN*8-1:0] rspec;
		logic rspec_ok;
		logic done;
		logic bad;
	} fam_prs_st_t;
	typedef struct packed {
		logic [`FAM_NEV-1:0] status;
		logic irq;
	} fam_irq_st_t;
endpackage : fam_pkg

//--- inc/fam_rq_if.sv
// Parsed flow-change request handed from the parser to the framer top
`timescale 1ns/100ps
`default_nettype none
`include "fam_defines.svh"
interface fam_rq_if;
	logic [7:0] orig;
	logic [7:0] flow;
	logic [`FAM_SPEC_LEN*8-1:0] spec;
	logic [7:0] dir;
	logic [7:0] rev;
	logic [`FAM_RSPEC_LEN*8-1:0] rspec;
	logic rspec_ok;
	logic done;
	logic bad;
	modport prs (output orig, flow, spec, dir, rev, rspec, rspec_ok, done, bad);
	modport top (input orig, flow, spec, dir, rev, rspec, rspec_ok, done, bad);
endinterface : fam_rq_if
`default_nettype wire

//--- tb/fam_framer_bench.sv
// Self-checking bench of the flow message framer
`timescale 1ns/100ps
`default_nettype none
module fam_framer_bench;
	logic ref_clk, resetn, avs_read, avs_write, avs_waitrequest;
	logic tx_ready, tx_valid, tx_last, rx_valid, rx_last, rx_ready, irq;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [7:0] tx_data, rx_data;
	logic [8:0] txq[$];
	logic [31:0] rdq[$];
	int failures, checks, c, d, t;
	fam_framer dut (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .tx_data, .tx_valid,
		.tx_last, .tx_ready, .rx_data, .rx_valid, .rx_last, .rx_ready, .irq);
	fam_peer peer (.ref_clk, .resetn, .tx_ready, .rx_data, .rx_valid,
		.rx_last);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic finish_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Watcher takes the oldest note whenever a result shows
	always @(posedge ref_clk) begin
		if (tx_valid && tx_ready) chk({tx_last, tx_data}, txq.pop_front());
		if (avs_read && !avs_waitrequest) chk(avs_readdata, rdq.pop_front());
	end
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] dat);
		int n;
		avs_address <= a;
		avs_writedata <= dat;
		avs_write <= wr;
		avs_read <= !wr;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (n == 20) begin
			failures++;
			finish_test;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask : bus
	task automatic rd(input logic [5:0] a, input logic [31:0] exp);
		rdq.push_back(exp);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic ex(input logic [7:0] v);
		txq.push_back({1'b0, v});
	endtask : ex
	// Bounded wait for both streams to fall quiet
	task automatic drain;
		int k;
		for (k = 0; k < 2000 && (txq.size() || tx_valid !== 1'b0 ||
			peer.rxq.size() || rx_valid !== 1'b0); k++) @(posedge ref_clk);
		if (k == 2000) begin
			failures++;
			finish_test;
		end
		repeat (4) @(posedge ref_clk);
	endtask : drain
	task automatic notice(input logic [7:0] code, input logic dir,
		input logic tun, input logic [3:0] n);
		logic [31:0] h, o;
		logic [7:0] p[$];
		int k;
		h = $urandom;
		h[23:16] = code;
		o = $urandom;
		o[23:16] = {n, 2'b00, tun, dir};
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 6'h04, h);
		bus(1'b1, 6'h08, o);
		for (k = 0; k < (dir ? 2 * n : n); k++) begin
			p.push_back(8'($urandom));
			bus(1'b1, 6'h0c, {19'h0, k[4:0], p[k]});
		end
		if (code <= 8'h02) begin
			ex(h[7:0]);
			ex(h[15:8]);
			ex(code);
			ex(code == 8'h02 ? o[7:0] : 8'h00);
			ex(code == 8'h02 ? o[15:8] : 8'h00);
			ex({7'h0, dir});
			if (dir) ex(o[31:24]);
			ex({7'h0, tun});
			ex(h[31:24]);
			if (tun) ex({4'h0, n});
			foreach (p[i]) if (tun) ex(p[i]);
			txq[txq.size() - 1][8] = 1'b1;
		end
		bus(1'b1, 6'h00, 32'h1);
		rd(6'h00, code <= 8'h02 ? 32'h2 : 32'h0);
		// Second start lands while the shortest notice is still leaving
		bus(1'b1, 6'h00, 32'h1);
		drain();
		chk({31'h0, irq}, {31'h0, code <= 8'h02});
		rd(6'h10, code <= 8'h02 ? 32'h1 : 32'h8);
		bus(1'b1, 6'h10, 32'hf);
		$display("notice code %h dir %0d tunnel %0d done", code, dir, tun);
	endtask : notice
	task automatic req(input logic [7:0] dir, input int len,
		input logic [31:0] st);
		logic [7:0] m[13];
		int k;
		for (k = 0; k < 13; k++) m[k] = 8'($urandom);
		m[7] = dir;
		for (k = 0; k < len; k++) peer.rxq.push_back({k == len - 1, m[k]});
		drain();
		chk({31'h0, irq}, 32'h0);
		rd(6'h10, st);
		if (st[1]) begin
			rd(6'h18, {dir[0] ? m[8] : 8'h00, 7'h0, dir[0], m[1], m[0]});
			rd(6'h1c, {m[5], m[4], m[3], m[2]});
			rd(6'h24, {31'h0, len == 13});
		end
		if (len == 13) rd(6'h20, {m[12], m[11], m[10], m[9]});
		bus(1'b1, 6'h10, 32'hf);
		$display("request dir %h length %0d done", dir, len);
	endtask : req
	initial begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		finish_test;
	end
	initial begin
		resetn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		void'($urandom(32'hd862));
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd(6'h10, 32'h0);
		rd(6'h3c, 32'h0);
		bus(1'b1, 6'h14, 32'h1);
		rd(6'h14, 32'h1);
		for (c = 0; c < 4; c++)
			for (d = 0; d < 2; d++)
				for (t = 0; t < 2; t++)
					notice(c[7:0], d[0], t[0], 4'($urandom_range(3)));
		notice(8'h02, 1'b1, 1'b1, 4'hf);
		rd(6'h00, 32'h0);
		rd(6'h0c, 32'h0);
		req(8'h00, 8, 32'h2);
		req(8'h01, 9, 32'h2);
		req(8'h01, 13, 32'h2);
		req(8'h01, 10, 32'h4);
		req(8'h02, 8, 32'h4);
		req(8'h00, 9, 32'h4);
		finish_test;
	end
endmodule : fam_framer_bench
`default_nettype wire

//--- tb/fam_peer.sv
// Far-end model: stalling notice sink and request source
`timescale 1ns/100ps
`default_nettype none
module fam_peer (
	input wire logic ref_clk,
	input wire logic resetn,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_last
);
	// Octet with end marker in bit 8, filled by the bench
	logic [8:0] rxq[$];
	initial begin
		tx_ready = 1'b0;
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_last = 1'b0;
	end
	always @(posedge ref_clk) begin
		// Random stalls exercise the hold of each octet
		tx_ready <= resetn && $urandom_range(3) != 0;
		if (rxq.size() != 0 && $urandom_range(2) != 0) begin
			rx_data <= rxq[0][7:0];
			rx_last <= rxq[0][8];
			rx_valid <= 1'b1;
			void'(rxq.pop_front());
		end else begin
			// Idle line inverts the octet on rx_data every cycle, so the stale octet shows again every second idle cycle
			rx_data <= ~rx_data;
			rx_valid <= 1'b0;
			rx_last <= 1'b0;
		end
	end
endmodule : fam_peer
`default_nettype wire

//--- tb/fam_properties.sv
// Port properties of the flow message framer
`timescale 1ns/100ps
`default_nettype none
module fam_properties (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	input wire logic tx_ready,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_last,
	input wire logic rx_ready,
	input wire logic irq
);
	logic wr_ok;
	logic tx_end;
	assign wr_ok = avs_write && !avs_waitrequest;
	assign tx_end = tx_valid && tx_ready && tx_last;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_bus_answer: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered");
	a_bus_one_low: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_bus_idle: assert property (
		!avs_read && !avs_write |=> avs_waitrequest)
		else $error("answer without request");
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
		else $error("octet changed while stalled");
	a_tx_start: assert property (
		$rose(tx_valid) |->
			$past(wr_ok && avs_address == 6'h00 && avs_writedata[0], 2))
		else $error("notice without start");
	a_tx_end_drop: assert property (
		tx_end |=> !tx_valid)
		else $error("octet after notice end");
	a_rx_open: assert property (
		rx_ready |=> rx_ready)
		else $error("request stream stalled");
	a_irq_cause: assert property (
		$rose(irq) |-> $past(tx_end) || $past(rx_valid && rx_last && rx_ready, 2)
			|| $past(wr_ok) || $past(wr_ok, 2))
		else $error("interrupt without event");
	c_notice: cover property (tx_end);
	c_request: cover property (rx_valid && rx_last);
	c_irq: cover property ($rose(irq));
endmodule : fam_properties
bind fam_framer fam_properties chk (.ref_clk, .resetn, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
	.tx_data, .tx_valid, .tx_last, .tx_ready, .rx_data, .rx_valid,
	.rx_last, .rx_ready, .irq);
`default_nettype wire
